// ==== spl_pkg.sv ====
package spl_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_INSERT = 8'hC2;
  localparam logic [7:0] ADDR_POWER  = 8'hC3;
  localparam logic [7:0] ADDR_SLEEP  = 8'hC4;
  localparam logic [7:0] ADDR_FWD    = 8'hC6;

  // ----------------------------------------
  // Reset values and writable bits
  // ----------------------------------------
  localparam logic [7:0] INSERT_RST   = 8'h00;
  localparam logic [7:0] POWER_RST    = 8'h00;
  localparam logic [7:0] SLEEP_RST    = 8'h50;
  localparam logic [7:0] FWD_RST      = 8'h00;
  localparam logic [7:0] INSERT_WMASK = 8'h0F;
  localparam logic [7:0] POWER_WMASK  = 8'hFF;
  localparam logic [7:0] SLEEP_WMASK  = 8'hFF;
  localparam logic [7:0] FWD_WMASK    = 8'h7B;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int INS_LSB      = 0;
  localparam int INS_W        = 4;
  localparam int CPU_PD_BIT   = 7;
  localparam int SW_PD_BIT    = 6;
  localparam int IND_MODE_LSB = 4;
  localparam int OUT_MODE_BIT = 3;
  localparam int PLL_OFF_BIT  = 2;
  localparam int PM_LSB       = 0;
  localparam int FWD_LSB      = 4;
  localparam int FWD_W        = 3;
  localparam int RMII_CLK_BIT = 3;
  localparam int HOST_LSB     = 0;

  localparam int NPORT        = 2;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SLEEP_UNIT_MS  = 20;
  localparam int CLK_KHZ        = 125000;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * CLK_KHZ;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    PM_NORMAL   = 2'h0,
    PM_ENERGY   = 2'h1,
    PM_SOFT_PD  = 2'h2,
    PM_SAVING   = 2'h3
  } spl_pm_type;

  typedef enum logic [1:0] {
    IND_LNKACT_SPEED  = 2'h0,
    IND_LINK_ACT      = 2'h1,
    IND_LNKACT_DUPLEX = 2'h2,
    IND_LINK_DUPLEX   = 2'h3
  } spl_ind_mode_type;

  typedef enum logic [1:0] {
    HOST_I2C_MASTER = 2'h0,
    HOST_I2C_SLAVE  = 2'h1,
    HOST_SPI_SLAVE  = 2'h2,
    HOST_SERIAL_MGT = 2'h3
  } spl_host_type;

  typedef enum logic [1:0] {
    SLP_AWAKE    = 2'h0,
    SLP_COUNTING = 2'h1,
    SLP_ASLEEP   = 2'h2
  } spl_sleep_type;

endpackage

// ==== spl_ind_if.sv ====
`timescale 1ns/1ps
interface spl_ind_if;
  spl_pkg::spl_ind_mode_type mode;
  logic                      debug_out;
  logic                      energy_stretched;
  logic                      device_ready;
  logic                      link_up;
  logic                      activity;
  logic                      speed_100;
  logic                      full_duplex;
  logic                      first_ind;
  logic                      second_ind;

  modport ctrl (
    output mode, debug_out, energy_stretched, device_ready,
    output link_up, activity, speed_100, full_duplex,
    input  first_ind, second_ind
  );
  modport drv (
    input  mode, debug_out, energy_stretched, device_ready,
    input  link_up, activity, speed_100, full_duplex,
    output first_ind, second_ind
  );
endinterface

// ==== spl_indicator.sv ====
`timescale 1ns/1ps
module spl_indicator (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  spl_ind_if.drv    ind
);

  // ----------------------------------------
  // Activity blink
  // ----------------------------------------
  logic blink_q;
  logic lnkact;
  logic act_pin;
  logic first_d;
  logic second_d;
  logic first_q;
  logic second_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // Resets low so a quiet link still reads as on
      blink_q <= 1'b0;
    end else if (ind.activity) begin
      blink_q <= ~blink_q;
    end
  end

  // Pins are active low: low means on
  always_comb begin
    lnkact   = ind.link_up ? blink_q : 1'b1;
    act_pin  = ~blink_q;
    first_d  = 1'b1;
    second_d = 1'b1;
    case (ind.mode)
      spl_pkg::IND_LNKACT_SPEED: begin
        first_d  = lnkact;
        second_d = ind.link_up ? ~ind.speed_100 : 1'b1;
      end
      spl_pkg::IND_LINK_ACT: begin
        first_d  = ~ind.link_up;
        second_d = act_pin;
      end
      spl_pkg::IND_LNKACT_DUPLEX: begin
        first_d  = lnkact;
        second_d = ind.link_up ? ~ind.full_duplex : 1'b1;
      end
      spl_pkg::IND_LINK_DUPLEX: begin
        first_d  = ~ind.link_up;
        second_d = ind.link_up ? ~ind.full_duplex : 1'b1;
      end
      default: begin
        first_d  = 1'b1;
        second_d = 1'b1;
      end
    endcase
    if (ind.debug_out) begin
      first_d  = ~ind.device_ready;
      second_d = ~ind.energy_stretched;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      first_q  <= 1'b1;
      second_q <= 1'b1;
    end else begin
      first_q  <= first_d;
      second_q <= second_d;
    end
  end

  assign ind.first_ind  = first_q;
  assign ind.second_ind = second_q;

endmodule

// ==== spl_config.sv ====
// Behaviour
// - Insertion bits enable default VLAN tag insertion
// - Bit 7 enables processor-side clock gating
// - Bit 6 enables switch clock gating
// - Indicator mode field selects indicator functions
// - Pins low when on; activity toggles
// - Debug mode outputs inverted energy and ready
// - PLL-off bit allows PLL power down
// - Power field selects operating mode
// - Sleep only after continuous no-energy period
// - Sleep delay in 20 ms steps, default 0x50
// - Port mask for invalid VLAN identifier frames
// - Host interface field, reset from straps
//
`timescale 1ns/1ps
module spl_config #(
  parameter int unsigned P_SLEEP_UNIT_CYCLES = spl_pkg::SLEEP_UNIT_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  input  wire logic        i_port2_indicator_hi_strap,
  input  wire logic        i_port2_indicator_lo_strap,
  input  wire logic        i_energy_present,
  input  wire logic        i_energy_stretched,
  input  wire logic        i_device_ready,
  input  wire logic [1:0]  i_link_up,
  input  wire logic [1:0]  i_activity,
  input  wire logic [1:0]  i_speed_100,
  input  wire logic [1:0]  i_full_duplex,
  output logic [3:0]       o_insert_port_default_vlan_id,
  output logic             o_cpu_clk_gate_en,
  output logic             o_switch_clk_gate_en,
  output logic             o_pll_power_down,
  output logic [1:0]       o_power_mode,
  output logic             o_low_power,
  output logic [2:0]       o_invalid_vlan_identifier_fwd,
  output logic             o_p3_rmii_clk_internal,
  output logic [1:0]       o_host_mode,
  output logic [1:0]       o_first_indicator,
  output logic [1:0]       o_second_indicator
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] strap_meta_q;
  logic [1:0] strap_sync_q;
  logic [1:0] ens_meta_q;
  logic [1:0] ens_sync_q;
  logic       energy_present;
  logic       energy_stretched;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_meta_q <= 2'h0;
      strap_sync_q <= 2'h0;
      ens_meta_q   <= 2'h0;
      ens_sync_q   <= 2'h0;
    end else begin
      strap_meta_q <= {i_port2_indicator_hi_strap,
                       i_port2_indicator_lo_strap};
      strap_sync_q <= strap_meta_q;
      ens_meta_q   <= {i_energy_present, i_energy_stretched};
      ens_sync_q   <= ens_meta_q;
    end
  end

  assign energy_present   = ens_sync_q[1];
  assign energy_stretched = ens_sync_q[0];

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  logic [1:0] strap_cnt_q;
  logic       strap_load;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != spl_pkg::STRAP_LOAD_CNT + 2'h1) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // Synchroniser needs two edges before the strap is trustworthy
  assign strap_load = (strap_cnt_q == spl_pkg::STRAP_LOAD_CNT);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] insert_q;
  logic [7:0] power_q;
  logic [7:0] sleep_q;
  logic [7:0] fwd_q;
  logic       wr_insert;
  logic       wr_power;
  logic       wr_sleep;
  logic       wr_fwd;

  assign wr_insert = i_reg_wr && (i_reg_addr == spl_pkg::ADDR_INSERT);
  assign wr_power  = i_reg_wr && (i_reg_addr == spl_pkg::ADDR_POWER);
  assign wr_sleep  = i_reg_wr && (i_reg_addr == spl_pkg::ADDR_SLEEP);
  assign wr_fwd    = i_reg_wr && (i_reg_addr == spl_pkg::ADDR_FWD);

  // Reserved bits are forced back to their defaults on every write except to FWD, which keeps their current value
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      insert_q <= spl_pkg::INSERT_RST;
    end else if (wr_insert) begin
      insert_q <= (i_reg_wdata & spl_pkg::INSERT_WMASK)
                | (spl_pkg::INSERT_RST & ~spl_pkg::INSERT_WMASK);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      power_q <= spl_pkg::POWER_RST;
    end else if (wr_power) begin
      power_q <= (i_reg_wdata & spl_pkg::POWER_WMASK)
               | (spl_pkg::POWER_RST & ~spl_pkg::POWER_WMASK);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_q <= spl_pkg::SLEEP_RST;
    end else if (wr_sleep) begin
      sleep_q <= (i_reg_wdata & spl_pkg::SLEEP_WMASK)
               | (spl_pkg::SLEEP_RST & ~spl_pkg::SLEEP_WMASK);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fwd_q <= spl_pkg::FWD_RST;
    end else if (strap_load) begin
      fwd_q[spl_pkg::HOST_LSB +: 2] <= strap_sync_q;
    end else if (wr_fwd) begin
      fwd_q <= (i_reg_wdata & spl_pkg::FWD_WMASK)
             | (fwd_q & ~spl_pkg::FWD_WMASK);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    case (i_reg_addr)
      spl_pkg::ADDR_INSERT: rdata_d = insert_q;
      spl_pkg::ADDR_POWER:  rdata_d = power_q;
      spl_pkg::ADDR_SLEEP:  rdata_d = sleep_q;
      spl_pkg::ADDR_FWD:    rdata_d = fwd_q;
      default:              rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // Energy-detect sleep timer
  // ----------------------------------------
  spl_pkg::spl_pm_type    pm_mode;
  spl_pkg::spl_sleep_type slp_q;
  logic [31:0]            cyc_q;
  logic [7:0]             unit_q;
  logic                   unit_tick;

  assign pm_mode   = spl_pkg::spl_pm_type'(power_q[spl_pkg::PM_LSB +: 2]);
  assign unit_tick = (cyc_q == P_SLEEP_UNIT_CYCLES - 1);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc_q <= 32'h0;
    end else if (slp_q != spl_pkg::SLP_COUNTING || unit_tick) begin
      cyc_q <= 32'h0;
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      unit_q <= 8'h00;
    end else if (slp_q != spl_pkg::SLP_COUNTING) begin
      unit_q <= 8'h00;
    end else if (unit_tick) begin
      unit_q <= unit_q + 8'h01;
    end
  end

  // Any energy restarts the whole period, so detection is consecutive
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slp_q <= spl_pkg::SLP_AWAKE;
    end else if (pm_mode != spl_pkg::PM_ENERGY || energy_present) begin
      slp_q <= spl_pkg::SLP_AWAKE;
    end else begin
      case (slp_q)
        spl_pkg::SLP_AWAKE:    slp_q <= spl_pkg::SLP_COUNTING;
        spl_pkg::SLP_COUNTING: begin
          if (unit_q >= sleep_q) begin
            slp_q <= spl_pkg::SLP_ASLEEP;
          end
        end
        spl_pkg::SLP_ASLEEP:   slp_q <= spl_pkg::SLP_ASLEEP;
        default:               slp_q <= spl_pkg::SLP_AWAKE;
      endcase
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_insert_port_default_vlan_id <= 4'h0;
      o_cpu_clk_gate_en             <= 1'b0;
      o_switch_clk_gate_en          <= 1'b0;
      o_pll_power_down              <= 1'b0;
      o_power_mode                  <= 2'h0;
      o_low_power                   <= 1'b0;
      o_invalid_vlan_identifier_fwd <= 3'h0;
      o_p3_rmii_clk_internal        <= 1'b0;
      o_host_mode                   <= 2'h0;
    end else begin
      o_insert_port_default_vlan_id <=
        insert_q[spl_pkg::INS_LSB +: spl_pkg::INS_W];
      o_cpu_clk_gate_en    <= power_q[spl_pkg::CPU_PD_BIT];
      o_switch_clk_gate_en <= power_q[spl_pkg::SW_PD_BIT];
      o_power_mode         <= pm_mode;
      o_low_power          <= (slp_q == spl_pkg::SLP_ASLEEP)
                           || pm_mode == spl_pkg::PM_SOFT_PD;
      // PLL may only drop while the energy-detect sleep holds
      o_pll_power_down     <= power_q[spl_pkg::PLL_OFF_BIT]
                           && slp_q == spl_pkg::SLP_ASLEEP;
      o_invalid_vlan_identifier_fwd <=
        fwd_q[spl_pkg::FWD_LSB +: spl_pkg::FWD_W];
      o_p3_rmii_clk_internal <= fwd_q[spl_pkg::RMII_CLK_BIT];
      o_host_mode          <= fwd_q[spl_pkg::HOST_LSB +: 2];
    end
  end

  // ----------------------------------------
  // Indicator drivers
  // ----------------------------------------
  spl_ind_if ind_bus [spl_pkg::NPORT] ();

  genvar gp;
  generate
    for (gp = 0; gp < spl_pkg::NPORT; gp++) begin : g_ind
      assign ind_bus[gp].mode = spl_pkg::spl_ind_mode_type'(
               power_q[spl_pkg::IND_MODE_LSB +: 2]);
      assign ind_bus[gp].debug_out = power_q[spl_pkg::OUT_MODE_BIT];
      assign ind_bus[gp].energy_stretched = energy_stretched;
      assign ind_bus[gp].device_ready     = i_device_ready;
      assign ind_bus[gp].link_up          = i_link_up[gp];
      assign ind_bus[gp].activity         = i_activity[gp];
      assign ind_bus[gp].speed_100        = i_speed_100[gp];
      assign ind_bus[gp].full_duplex      = i_full_duplex[gp];
      assign o_first_indicator[gp]        = ind_bus[gp].first_ind;
      assign o_second_indicator[gp]       = ind_bus[gp].second_ind;

      spl_indicator u_ind (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .ind       (ind_bus[gp])
      );
    end
  endgenerate

endmodule

// ==== spl_config_props.sv ====
`timescale 1ns/1ps
module spl_config_props (
  input wire logic       i_sys_clk,
  input wire logic       i_resetn,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_port2_indicator_hi_strap,
  input wire logic       i_port2_indicator_lo_strap,
  input wire logic [3:0] o_insert_port_default_vlan_id,
  input wire logic       o_cpu_clk_gate_en,
  input wire logic       o_switch_clk_gate_en,
  input wire logic       o_pll_power_down,
  input wire logic [1:0] o_power_mode,
  input wire logic       o_low_power,
  input wire logic [2:0] o_invalid_vlan_identifier_fwd,
  input wire logic [1:0] o_host_mode
);
  // ----------------------------------------
  // Write to output, two edges later; PLL down only in energy-detect mode
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_cpu_gate;
    i_reg_wr && i_reg_addr == spl_pkg::ADDR_POWER |=> ##1
      o_cpu_clk_gate_en == $past(i_reg_wdata[7], 2);
  endproperty
  a_cpu_gate: assert property (p_cpu_gate)
    else $error("cpu clock gate enable wrong");

  property p_sw_gate;
    i_reg_wr && i_reg_addr == spl_pkg::ADDR_POWER |=> ##1
      o_switch_clk_gate_en == $past(i_reg_wdata[6], 2);
  endproperty
  a_sw_gate: assert property (p_sw_gate)
    else $error("switch clock gate enable wrong");

  property p_pm;
    i_reg_wr && i_reg_addr == spl_pkg::ADDR_POWER |=> ##1
      o_power_mode == $past(i_reg_wdata[1:0], 2);
  endproperty
  a_pm: assert property (p_pm)
    else $error("power mode wrong");

  property p_ins;
    i_reg_wr && i_reg_addr == spl_pkg::ADDR_INSERT |=> ##1
      o_insert_port_default_vlan_id == $past(i_reg_wdata[3:0], 2);
  endproperty
  a_ins: assert property (p_ins)
    else $error("insertion enables wrong");

  property p_fwd;
    i_reg_wr && i_reg_addr == spl_pkg::ADDR_FWD |=> ##1
      o_invalid_vlan_identifier_fwd == $past(i_reg_wdata[6:4], 2);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("invalid vlan forward mask wrong");

  property p_soft_pd;
    i_reg_wr && i_reg_addr == spl_pkg::ADDR_POWER
      && i_reg_wdata[1:0] == 2'h2 |=> ##1 o_low_power;
  endproperty
  a_soft_pd: assert property (p_soft_pd)
    else $error("soft power down not applied");

  property p_pll;
    $rose(o_pll_power_down) |-> o_power_mode == 2'h1;
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll down outside energy detect");

  // Straps land four edges after release
  property p_strap;
    $rose(i_resetn) |-> ##4 o_host_mode ==
      {i_port2_indicator_hi_strap, i_port2_indicator_lo_strap};
  endproperty
  a_strap: assert property (p_strap)
    else $error("host mode not strapped");
endmodule

bind spl_config spl_config_props i_props (.*);

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic       i_sys_clk, i_resetn, i_reg_wr, i_reg_rd, o_reg_rvalid;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic       i_port2_indicator_hi_strap, i_port2_indicator_lo_strap;
  logic       i_energy_present, i_energy_stretched, i_device_ready;
  logic [1:0] i_link_up, i_activity, i_speed_100, i_full_duplex;
  logic [3:0] o_insert_port_default_vlan_id;
  logic       o_cpu_clk_gate_en, o_switch_clk_gate_en, o_pll_power_down;
  logic       o_low_power, o_p3_rmii_clk_internal;
  logic [1:0] o_power_mode, o_host_mode;
  logic [2:0] o_invalid_vlan_identifier_fwd;
  logic [1:0] o_first_indicator, o_second_indicator;
  int         n_mismatch, checked;

  // Short sleep unit keeps the energy-detect run brief
  spl_config #(.P_SLEEP_UNIT_CYCLES(4)) i_dut (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task final_report;
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task wr(input logic [7:0] a, d);
    @(posedge i_sys_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Data only counts when the valid pulse is there
  task rd(input logic [7:0] a, exp, input string nm);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(nm, o_reg_rvalid === 1'b1 ? o_reg_rdata : 8'hXX, exp);
  endtask

  task ind_case(input logic [7:0] pwr, input logic [1:0] lk, spd, dup,
                input bit sel, input logic [1:0] exp);
    wr(spl_pkg::ADDR_POWER, pwr);
    @(posedge i_sys_clk);
    i_link_up     <= lk;
    i_speed_100   <= spd;
    i_full_duplex <= dup;
    cyc(5);
    chk("ind", sel ? o_second_indicator : o_first_indicator, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(spl_pkg::ADDR_INSERT, 8'h00, "ins");
    rd(spl_pkg::ADDR_POWER, 8'h00, "pwr");
    rd(spl_pkg::ADDR_SLEEP, 8'h50, "slp");
    rd(spl_pkg::ADDR_FWD, 8'h02, "fwd");
    rd(8'hC5, 8'h00, "unmapped");
    chk("host", o_host_mode, 8'h02);
    chk("first", o_first_indicator, 8'h03);
  endtask

  task t_regs;
    wr(spl_pkg::ADDR_INSERT, 8'hFF);
    rd(spl_pkg::ADDR_INSERT, 8'h0F, "ins");
    chk("ins_out", o_insert_port_default_vlan_id, 8'h0F);
    wr(spl_pkg::ADDR_POWER, 8'hC0);
    cyc(3);
    chk("cpu", o_cpu_clk_gate_en, 8'h01);
    chk("sw", o_switch_clk_gate_en, 8'h01);
    wr(spl_pkg::ADDR_POWER, 8'h40);
    cyc(3);
    chk("cpu", o_cpu_clk_gate_en, 8'h00);
    chk("sw", o_switch_clk_gate_en, 8'h01);
    wr(spl_pkg::ADDR_FWD, 8'hFF);
    rd(spl_pkg::ADDR_FWD, 8'h7B, "fwd");
    chk("fwd_out", o_invalid_vlan_identifier_fwd, 8'h07);
    chk("rmii", o_p3_rmii_clk_internal, 8'h01);
    chk("host", o_host_mode, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(spl_pkg::ADDR_POWER, 8'(m));
      cyc(4);
      chk("pm", o_power_mode, 8'(m));
      chk("lowp", o_low_power, 8'(m == 2));
    end
    wr(spl_pkg::ADDR_SLEEP, 8'hA5);
    rd(spl_pkg::ADDR_SLEEP, 8'hA5, "slp");
  endtask

  // No-energy must last two units before sleep
  task t_sleep(input logic [7:0] pwr, input logic [7:0] pll);
    wr(spl_pkg::ADDR_SLEEP, 8'h02);
    wr(spl_pkg::ADDR_POWER, pwr);
    cyc(4);
    @(posedge i_sys_clk);
    i_energy_present <= 1'b0;
    cyc(8);
    chk("early", o_low_power, 8'h00);
    for (int i = 0; i < 40 && o_low_power !== 1'b1; i++) cyc(1);
    chk("asleep", o_low_power, 8'h01);
    chk("pll", o_pll_power_down, pll);
    @(posedge i_sys_clk);
    i_energy_present <= 1'b1;
    cyc(8);
    chk("wake", o_low_power, 8'h00);
    chk("pll", o_pll_power_down, 8'h00);
  endtask

  task t_ind;
    ind_case(8'h00, 2'h3, 2'h1, 2'h0, 1, 2'h2);
    chk("lnkact", o_first_indicator, 8'h00);
    ind_case(8'h10, 2'h1, 2'h0, 2'h0, 0, 2'h2);
    chk("act", o_second_indicator[0], 8'h01);
    @(posedge i_sys_clk);
    i_activity <= 2'h1;
    @(posedge i_sys_clk);
    i_activity <= 2'h0;
    cyc(4);
    chk("act", o_second_indicator[0], 8'h00);
    ind_case(8'h20, 2'h3, 2'h0, 2'h2, 1, 2'h1);
    ind_case(8'h30, 2'h2, 2'h0, 2'h3, 0, 2'h1);
    ind_case(8'h30, 2'h1, 2'h0, 2'h3, 1, 2'h2);
    @(posedge i_sys_clk);
    i_device_ready <= 1'b1;
    ind_case(8'h08, 2'h1, 2'h0, 2'h0, 0, 2'h0);
    chk("dbg2", o_second_indicator, 8'h03);
    @(posedge i_sys_clk);
    i_energy_stretched <= 1'b1;
    cyc(6);
    chk("dbg2", o_second_indicator, 8'h00);
  endtask

  task t_strap;
    @(posedge i_sys_clk);
    i_port2_indicator_hi_strap <= 1'b0;
    i_port2_indicator_lo_strap <= 1'b1;
    i_resetn <= 1'b0;
    cyc(2);
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    cyc(6);
    rd(spl_pkg::ADDR_FWD, 8'h01, "fwd");
    rd(spl_pkg::ADDR_INSERT, 8'h00, "ins");
    chk("host", o_host_mode, 8'h01);
  endtask

  // ----------------------------------------
  // Clock, sequence, watchdog
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    {i_resetn, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    {i_energy_stretched, i_device_ready, i_activity} = '0;
    {i_link_up, i_speed_100, i_full_duplex} = '0;
    i_energy_present = 1'b1;
    i_port2_indicator_hi_strap = 1'b1;
    i_port2_indicator_lo_strap = 1'b0;
    repeat (10) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    cyc(6);
    t_reset;
    t_regs;
    t_sleep(8'h05, 8'h01);
    t_sleep(8'h01, 8'h00);
    t_ind;
    t_strap;
    final_report;
  end

  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
endmodule
